// File: common/wtc_consts.svh
`ifndef WTC_CONSTS_SVH
`define WTC_CONSTS_SVH
// Notes on behaviour
// - 8-bit variant decodes 257 wiper positions over a 256-element ladder.
// - 7-bit variant decodes 129 wiper positions over a 128-element ladder.
// - Exactly one tap switch closes, picked by the volatile wiper value.
// - Wiper value zero connects the wiper straight to terminal B.
// - Full-scale value, 100h or 80h, connects the wiper straight to terminal A.
// - Values above full scale also decode as full scale.
// - Increment ignored at or above full scale; decrement ignored at zero or above full scale.
// - Lock blocks serial changes to volatile wiper, stored wiper and terminal bits.
// - Two lock bits, one per network, each guarding only its own network.
// - Each lock covers stored wiper, volatile wiper and four terminal bits.
// - Lock bits change only through high-voltage step commands.
// - Lock bits survive supply and brown-out resets.
// - Supply or brown-out reset reloads volatile wiper from the stored wiper.
// - Power-down pin opens both A terminals and ties each wiper to its B.
// - Power-down pin leaves the serial port working and stored writes finishing.
// - Power-down pin keeps wiper and terminal bits; they govern again on release.
// - Each force-off bit gives its network the power-down pin arrangement.
// - While forced off, connect bits are ignored but kept, then govern again.
// - A, wiper and B connect bits gate each terminal independently.
// - Force-off bit acts on one network, pin on both; either source applies.
// - Device is a serial slave and never drives the serial clock.
// - Mode 0,0 or 1,1 chosen from clock level when chip select goes active.
// - A connect bit of one connects its pin, zero disconnects it.
`define WTC_FS8       10'h100
`define WTC_FS7       10'h080
`define WTC_TERMINAL_CONNECT_REG_RST  8'hFF
`define WTC_ADDR_VW0  4'h0
`define WTC_ADDR_VW1  4'h1
`define WTC_ADDR_NV0  4'h2
`define WTC_ADDR_NV1  4'h3
`define WTC_ADDR_TERMINAL_CONNECT_REG 4'h4
`define WTC_ADDR_LOCK 4'h5
`define WTC_TC_FORCE  3
`define WTC_TC_A      2
`define WTC_TC_W      1
`define WTC_TC_B      0
`define WTC_NET1_LSB  4
`endif

// File: common/wtc_pkg.sv
package wtc_pkg;
  typedef enum logic [1:0] {
    OP_WRITE = 2'b00,
    OP_INC   = 2'b01,
    OP_DEC   = 2'b10,
    OP_READ  = 2'b11
  } op_t;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_CMD  = 2'b01,
    S_DATA = 2'b10
  } spi_state_t;
endpackage : wtc_pkg

// File: core/wiper_network.sv
`timescale 1ns/100ps
`include "wtc_consts.svh"
module wiper_network import wtc_pkg::*; (
  input  wire logic [9:0]   wiper,
  input  wire logic         res_8bit,
  input  wire logic         pin_power_down_n,
  input  wire logic [3:0]   terminal_connect_reg_nib,
  output logic      [256:0] tap,
  output logic              conn_a,
  output logic              conn_w,
  output logic              conn_b
);
  logic [9:0] full;
  logic [9:0] pos;
  logic       forced;

  // Saturating decode; the reserved range collapses onto terminal A
  always_comb begin
    full   = res_8bit ? `WTC_FS8 : `WTC_FS7;
    pos    = (wiper >= full) ? full : wiper;
    forced = !pin_power_down_n || !terminal_connect_reg_nib[`WTC_TC_FORCE];
    tap    = '0;
    // One-hot by construction, so two switches can never short ladder nodes
    if (forced) begin
      tap[0] = 1'b1;
    end else begin
      tap[pos[8:0]] = 1'b1;
    end
    // Forcing overrides the connect bits without touching them
    conn_a = forced ? 1'b0 : terminal_connect_reg_nib[`WTC_TC_A];
    conn_w = forced ? 1'b1 : terminal_connect_reg_nib[`WTC_TC_W];
    conn_b = forced ? 1'b1 : terminal_connect_reg_nib[`WTC_TC_B];
  end
endmodule : wiper_network

// File: core/wiper_terminal_control.sv
`timescale 1ns/100ps
`include "wtc_consts.svh"
module wiper_terminal_control import wtc_pkg::*; (
  input  wire logic         CLK_SYS,
  input  wire logic         RESETN,
  input  wire logic         CE,
  input  wire logic         SCK,
  input  wire logic         CS_N,
  input  wire logic         CS_HV,
  input  wire logic         SDI,
  input  wire logic         HW_POWER_DOWN_PIN_N,
  input  wire logic         RES_8BIT,
  input  wire logic [9:0]   NV_WIPER0,
  input  wire logic [9:0]   NV_WIPER1,
  input  wire logic [1:0]   NV_LOCK,
  output logic              NV_WR_EN,
  output logic      [3:0]   NV_WR_ADDR,
  output logic      [9:0]   NV_WR_DATA,
  output logic      [9:0]   WIPER0,
  output logic      [9:0]   WIPER1,
  output logic      [7:0]   TERMINAL_CONNECT_REG,
  output logic              LOCK_BIT_NET0,
  output logic              LOCK_BIT_NET1,
  output logic              SPI_MODE11,
  output logic      [256:0] NET0_TAP,
  output logic      [256:0] NET1_TAP,
  output logic              NET0_TERM_A,
  output logic              NET0_WIPER,
  output logic              NET0_TERM_B,
  output logic              NET1_TERM_A,
  output logic              NET1_WIPER,
  output logic              NET1_TERM_B
);

  typedef struct packed {
    logic [1:0]   cs_s;
    logic [1:0]   sck_s;
    logic [1:0]   sdi_s;
    logic [1:0]   hv_s;
    logic [1:0]   pd_s;
    logic [1:0]   res_s;
    logic         cs_d;
    logic         sck_d;
    spi_state_t   st;
    logic [2:0]   bit_cnt;
    logic [7:0]   shift;
    logic [7:0]   cmd_byte;
    logic         hv_frame;
    logic         mode11;
    logic         loaded;
    logic [9:0]   wiper0;
    logic [9:0]   wiper1;
    logic [7:0]   terminal_connect_reg;
    logic [1:0]   lock;
    logic         nv_wr_en;
    logic [3:0]   nv_wr_addr;
    logic [9:0]   nv_wr_data;
    logic [256:0] tap0;
    logic [256:0] tap1;
    logic [2:0]   conn0;
    logic [2:0]   conn1;
  } state_t;

  state_t       r;
  state_t       n;
  logic [9:0]   full_scale;
  logic         cs_fall;
  logic         sck_rise;
  logic         active;
  logic [7:0]   byte_in;
  logic [3:0]   addr_in;
  logic [9:0]   data_in;
  logic         wr_vw0;
  logic         wr_terminal_connect_reg;
  logic [256:0] tap0_c;
  logic [256:0] tap1_c;
  logic [2:0]   conn0_c;
  logic [2:0]   conn1_c;

  // Step with the limits of the decode map; reserved codes never move
  function automatic logic [9:0] wiper_step(input logic [9:0] v, input logic [9:0] fs, input logic up);
    if (up) begin
      wiper_step = (v >= fs) ? v : v + 10'h001;
    end else begin
      wiper_step = ((v == 10'h000) || (v > fs)) ? v : v - 10'h001;
    end
  endfunction : wiper_step

  // Edge detection looks at second synchroniser stages only
  assign full_scale = r.res_s[1] ? `WTC_FS8 : `WTC_FS7;
  assign active     = !r.cs_s[1];
  assign cs_fall    = r.cs_d && !r.cs_s[1];
  assign sck_rise   = !r.sck_d && r.sck_s[1];
  assign byte_in    = {r.shift[6:0], r.sdi_s[1]};
  assign addr_in    = byte_in[7:4];
  assign data_in    = {r.cmd_byte[1:0], byte_in};

  // Each network has its own decoder instance; only the nibble and wiper differ
  wiper_network u_net0 (
    .wiper            (r.wiper0),
    .res_8bit         (r.res_s[1]),
    .pin_power_down_n (r.pd_s[1]),
    .terminal_connect_reg_nib         (r.terminal_connect_reg[3:0]),
    .tap              (tap0_c),
    .conn_a           (conn0_c[2]),
    .conn_w           (conn0_c[1]),
    .conn_b           (conn0_c[0])
  );

  wiper_network u_net1 (
    .wiper            (r.wiper1),
    .res_8bit         (r.res_s[1]),
    .pin_power_down_n (r.pd_s[1]),
    .terminal_connect_reg_nib         (r.terminal_connect_reg[7:4]),
    .tap              (tap1_c),
    .conn_a           (conn1_c[2]),
    .conn_w           (conn1_c[1]),
    .conn_b           (conn1_c[0])
  );

  // Next-state logic; the power-down pin reaches only pd_s and the tap and connect copies, never serial decoding
  always_comb begin
    n            = r;
    wr_vw0       = 1'b0;
    wr_terminal_connect_reg      = 1'b0;
    n.nv_wr_en   = 1'b0;
    n.cs_s       = {r.cs_s[0], CS_N};
    n.sck_s      = {r.sck_s[0], SCK};
    n.sdi_s      = {r.sdi_s[0], SDI};
    n.hv_s       = {r.hv_s[0], CS_HV};
    n.pd_s       = {r.pd_s[0], HW_POWER_DOWN_PIN_N};
    n.res_s      = {r.res_s[0], RES_8BIT};
    n.cs_d       = r.cs_s[1];
    n.sck_d      = r.sck_s[1];
    n.tap0       = tap0_c;
    n.tap1       = tap1_c;
    n.conn0      = conn0_c;
    n.conn1      = conn1_c;
    if (!r.loaded) begin
      // Recall after reset release; locks live outside and are only read back
      n.wiper0 = NV_WIPER0;
      n.wiper1 = NV_WIPER1;
      n.lock   = NV_LOCK;
      n.loaded = 1'b1;
    end else if (!active) begin
      // A raised select drops any partial byte
      n.st = S_IDLE;
    end else if (cs_fall) begin
      // Mode and high-voltage level are latched once, at the select edge
      n.mode11   = r.sck_s[1];
      n.hv_frame = r.hv_s[1];
      n.st       = S_CMD;
      n.bit_cnt  = 3'h0;
    end else if (sck_rise && (r.st != S_IDLE)) begin
      // Serial decoding carries on while powered down
      n.shift   = byte_in;
      n.bit_cnt = r.bit_cnt + 3'h1;
      if (r.bit_cnt == 3'h7) begin
        unique case (r.st)
          S_IDLE: begin
            n.st = S_IDLE;
          end
          S_CMD: begin
            if (byte_in[3:2] == OP_WRITE) begin
              n.cmd_byte = byte_in;
              n.st       = S_DATA;
            end else if ((byte_in[3:2] == OP_INC) || (byte_in[3:2] == OP_DEC)) begin
              if (r.hv_frame) begin
                // Only a high-voltage step on a stored wiper address moves a lock
                if ((addr_in == `WTC_ADDR_NV0) || (addr_in == `WTC_ADDR_NV1)) begin
                  n.lock[addr_in[0]] = (byte_in[3:2] == OP_DEC);
                  n.nv_wr_en         = 1'b1;
                  n.nv_wr_addr       = `WTC_ADDR_LOCK;
                  n.nv_wr_data       = {8'h00, n.lock};
                end
              end else if ((addr_in == `WTC_ADDR_VW0) && !r.lock[0]) begin
                n.wiper0 = wiper_step(r.wiper0, full_scale, byte_in[3:2] == OP_INC);
              end else if ((addr_in == `WTC_ADDR_VW1) && !r.lock[1]) begin
                n.wiper1 = wiper_step(r.wiper1, full_scale, byte_in[3:2] == OP_INC);
              end
            end
          end
          // Second byte of a write carries the low eight value bits
          S_DATA: begin
            n.st = S_CMD;
            unique case (r.cmd_byte[7:4])
              `WTC_ADDR_VW0: begin
                if (!r.lock[0]) begin
                  n.wiper0 = data_in;
                  wr_vw0   = 1'b1;
                end
              end
              `WTC_ADDR_VW1: begin
                if (!r.lock[1]) begin
                  n.wiper1 = data_in;
                end
              end
              `WTC_ADDR_NV0, `WTC_ADDR_NV1: begin
                if (!r.lock[r.cmd_byte[4]]) begin
                  n.nv_wr_en   = 1'b1;
                  n.nv_wr_addr = r.cmd_byte[7:4];
                  n.nv_wr_data = data_in;
                end
              end
              `WTC_ADDR_TERMINAL_CONNECT_REG: begin
                // Each nibble is guarded by its own network's lock
                wr_terminal_connect_reg = !r.lock[0];
                if (!r.lock[0]) begin
                  n.terminal_connect_reg[3:0] = data_in[3:0];
                end
                if (!r.lock[1]) begin
                  n.terminal_connect_reg[7:4] = data_in[7:4];
                end
              end
              default: begin
                // Lock location and unmapped addresses take no plain write
                n.st = S_CMD;
              end
            endcase
          end
          default: begin
            n.st = S_IDLE;
          end
        endcase
      end
    end
  end

  // State register; clock enable low freezes everything
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      // Select and power-down synchronisers start high, so no false edge follows reset
      r      <= '0;
      r.terminal_connect_reg <= `WTC_TERMINAL_CONNECT_REG_RST;
      r.cs_s <= 2'b11;
      r.cs_d <= 1'b1;
      r.pd_s <= 2'b11;
    end else if (CE) begin
      r <= n;
    end
  end

  // Outputs come straight from the state register
  assign NV_WR_EN             = r.nv_wr_en;
  assign NV_WR_ADDR           = r.nv_wr_addr;
  assign NV_WR_DATA           = r.nv_wr_data;
  assign WIPER0               = r.wiper0;
  assign WIPER1               = r.wiper1;
  assign TERMINAL_CONNECT_REG = r.terminal_connect_reg;
  assign LOCK_BIT_NET0        = r.lock[0];
  assign LOCK_BIT_NET1        = r.lock[1];
  assign SPI_MODE11           = r.mode11;
  assign NET0_TAP             = r.tap0;
  assign NET1_TAP             = r.tap1;
  assign NET0_TERM_A          = r.conn0[2];
  assign NET0_WIPER           = r.conn0[1];
  assign NET0_TERM_B          = r.conn0[0];
  assign NET1_TERM_A          = r.conn1[2];
  assign NET1_WIPER           = r.conn1[1];
  assign NET1_TERM_B          = r.conn1[0];

  // Checks on the tap decode
  a_tap_onehot: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    r.loaded |-> ($onehot(r.tap0) && $onehot(r.tap1)))
    else $error("tap select not one-hot");

  a_zero_to_b: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (CE && r.loaded && (r.wiper0 == 10'h000)) |=> r.tap0[0])
    else $error("zero wiper not on terminal B");

  a_full_to_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (CE && r.res_s[1] && r.pd_s[1] && r.terminal_connect_reg[3] && (r.wiper0 >= 10'h100)) |=> r.tap0[256])
    else $error("full scale not on terminal A");

  a_full_to_a7: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (CE && !r.res_s[1] && r.pd_s[1] && r.terminal_connect_reg[3] && (r.wiper0 >= 10'h080)) |=> r.tap0[128])
    else $error("7-bit full scale not on terminal A");

  // Checks on stepping limits and locking
  a_inc_at_full: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (CE && r.loaded && !wr_vw0 && (r.wiper0 >= full_scale)) |=> (r.wiper0 <= $past(r.wiper0)))
    else $error("increment moved wiper past full scale");

  a_dec_at_zero: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (CE && r.loaded && !wr_vw0 && ((r.wiper0 == 10'h000) || (r.wiper0 > full_scale)))
    |=> (r.wiper0 >= $past(r.wiper0)))
    else $error("decrement moved wiper from zero or reserved code");

  a_lock_holds: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (CE && r.loaded && r.lock[0]) |=> ($stable(r.wiper0) && $stable(r.terminal_connect_reg[3:0])))
    else $error("locked network changed");

  a_reload: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    $rose(r.loaded) |-> ((r.wiper0 == $past(NV_WIPER0)) && (r.lock == $past(NV_LOCK))))
    else $error("reset recall wrong");

  // Checks on power-down, terminal gating and mode pick
  a_pin_down: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (CE && !r.pd_s[1]) |=> (!r.conn0[2] && !r.conn1[2] && r.tap0[0] && r.tap1[0]))
    else $error("pin power-down arrangement wrong");

  a_force_off: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (CE && !r.terminal_connect_reg[3]) |=> (!r.conn0[2] && r.conn0[0] && r.tap0[0]))
    else $error("force-off arrangement wrong");

  a_bits_gate: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (CE && r.pd_s[1] && r.terminal_connect_reg[3]) |=> (r.conn0 == $past(r.terminal_connect_reg[2:0])))
    else $error("connect bits not in control");

  a_mode_pick: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (CE && r.loaded && active && cs_fall) |=> (r.mode11 == $past(r.sck_s[1])))
    else $error("mode not taken from clock level");

  // Checks on the second network and the lock path
  a_lock1_holds: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (CE && r.loaded && r.lock[1]) |=> ($stable(r.wiper1) && $stable(r.terminal_connect_reg[7:4])))
    else $error("locked second network changed");

  a_force_off1: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (CE && !r.terminal_connect_reg[7]) |=> (!r.conn1[2] && r.conn1[1] && r.conn1[0] && r.tap1[0]))
    else $error("second force-off arrangement wrong");

  a_bits_gate1: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (CE && r.pd_s[1] && r.terminal_connect_reg[7]) |=> (r.conn1 == $past(r.terminal_connect_reg[6:4])))
    else $error("second connect bits not in control");

  a_zero_to_b1: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (CE && r.loaded && (r.wiper1 == 10'h000)) |=> r.tap1[0])
    else $error("second zero wiper not on terminal B");

  a_full_to_a1: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (CE && r.res_s[1] && r.pd_s[1] && r.terminal_connect_reg[7] && (r.wiper1 >= 10'h100)) |=> r.tap1[256])
    else $error("second full scale not on terminal A");

  a_nv_locked: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (CE && r.loaded && r.lock[0]) |=> !(r.nv_wr_en && (r.nv_wr_addr == `WTC_ADDR_NV0)))
    else $error("stored wiper written while locked");

  a_lock_plain: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (CE && r.loaded && !r.hv_frame) |=> $stable(r.lock))
    else $error("lock changed outside a high-voltage frame");

  a_terminal_connect_reg_write: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (CE && wr_terminal_connect_reg) |=> (r.terminal_connect_reg[3:0] == $past(data_in[3:0])))
    else $error("terminal bits not written");

endmodule : wiper_terminal_control

// File: verification/spi_host_model.sv
`timescale 1ns/100ps
// Host end of the serial link; it alone makes the clock and frames transfers
module spi_host_model (
  input  wire logic clk,
  output logic      sck,
  output logic      cs_n,
  output logic      cs_hv,
  output logic      sdi
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    cs_hv = 1'b0;
    sdi = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // Idle level goes out well before select, so the mode sample sees a settled clock
  task automatic frame(input logic m11, input logic hv, input logic two, input logic [15:0] d);
    tick(1);
    sck <= m11;
    tick(4);
    cs_n <= 1'b0;
    cs_hv <= hv;
    tick(4);
    for (int i = 15; i >= (two ? 0 : 8); i--) begin
      sck <= 1'b0;
      sdi <= d[i];
      tick(4);
      sck <= 1'b1;
      tick(4);
    end
    sck <= m11;
    tick(4);
    cs_n <= 1'b1;
    cs_hv <= 1'b0;
    sdi <= ~sdi; // Released line must not keep showing the last bit
    tick(4);
  endtask : frame
endmodule : spi_host_model

// File: verification/wiper_terminal_control_tb.sv
`timescale 1ns/100ps
module wiper_terminal_control_tb;
  import wtc_pkg::*;
  logic         clk_sys = 1'b0;
  logic         resetn = 1'b0;
  logic         pd_n = 1'b1;
  logic         ce = 1'b1;
  logic         r8 = 1'b1;
  logic [9:0]   nv_wiper0;
  logic [9:0]   nv_wiper1 = 10'h3FF;
  logic [1:0]   nv_lock = 2'h0;
  logic [9:0]   wr_cnt = 10'h000;
  logic [3:0]   wr_addr = 4'h0;
  logic [9:0]   wr_data = 10'h000;
  logic         sck, cs_n, cs_hv, sdi, nv_wr_en, lk0, lk1, mode11;
  logic [3:0]   nv_wr_addr;
  logic [9:0]   nv_wr_data, wiper0, wiper1;
  logic [7:0]   terminal_connect_reg;
  logic [256:0] tap0, tap1;
  wire  [2:0]   cn0, cn1;
  int           w[2], nv[2], lk[2], tc, fs, exp_wr, exp_addr, exp_data, errors, samples_checked;
  logic         m11;

  always #10 clk_sys = ~clk_sys;

  spi_host_model host (.clk(clk_sys), .sck(sck), .cs_n(cs_n), .cs_hv(cs_hv), .sdi(sdi));

  wiper_terminal_control dut (.CLK_SYS(clk_sys), .RESETN(resetn), .CE(ce), .SCK(sck), .CS_N(cs_n),
    .CS_HV(cs_hv), .SDI(sdi), .HW_POWER_DOWN_PIN_N(pd_n), .RES_8BIT(r8), .NV_WIPER0(nv_wiper0),
    .NV_WIPER1(nv_wiper1), .NV_LOCK(nv_lock), .NV_WR_EN(nv_wr_en), .NV_WR_ADDR(nv_wr_addr),
    .NV_WR_DATA(nv_wr_data), .WIPER0(wiper0), .WIPER1(wiper1), .TERMINAL_CONNECT_REG(terminal_connect_reg),
    .LOCK_BIT_NET0(lk0), .LOCK_BIT_NET1(lk1), .SPI_MODE11(mode11), .NET0_TAP(tap0), .NET1_TAP(tap1),
    .NET0_TERM_A(cn0[2]), .NET0_WIPER(cn0[1]), .NET0_TERM_B(cn0[0]), .NET1_TERM_A(cn1[2]),
    .NET1_WIPER(cn1[1]), .NET1_TERM_B(cn1[0]));

  // External storage: keeps what the block stores, so a reset really recalls it
  always @(posedge clk_sys) begin
    if (nv_wr_en === 1'b1) begin
      wr_cnt <= wr_cnt + 10'h001;
      wr_addr <= nv_wr_addr;
      wr_data <= nv_wr_data;
      if (nv_wr_addr == 4'h2) nv_wiper0 <= nv_wr_data;
      if (nv_wr_addr == 4'h3) nv_wiper1 <= nv_wr_data;
      if (nv_wr_addr == 4'h5) nv_lock <= nv_wr_data[1:0];
    end
  end

  task automatic cmp_val(input string what, input logic [9:0] seen, input int exp);
    samples_checked++;
    if (seen !== exp[9:0]) begin
      errors++;
      $display("FAIL %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : cmp_val

  task automatic cmp_tap(input string what, input logic [256:0] seen, input int idx);
    logic [256:0] e;
    e = '0;
    e[idx] = 1'b1;
    samples_checked++;
    if (seen !== e) begin
      errors++;
      $display("FAIL %s expected %0h seen %0h", what, e, seen);
    end
  endtask : cmp_tap

  // Forced networks sit on B with A open; otherwise the nibble rules the switches
  task automatic check_all();
    bit f;
    for (int n = 0; n < 2; n++) begin
      f = !pd_n || !tc[4*n+3];
      cmp_val("wiper", n ? wiper1 : wiper0, w[n]);
      cmp_tap("tap", n ? tap1 : tap0, f ? 0 : (w[n] > fs ? fs : w[n]));
      cmp_val("conn", {7'h00, n ? cn1 : cn0}, f ? 3 : (tc >> (4*n)) & 7);
      cmp_val("lock", n ? lk1 : lk0, lk[n]);
    end
    cmp_val("terminal_connect_reg", terminal_connect_reg, tc);
    cmp_val("mode", mode11, m11);
    cmp_val("nv count", wr_cnt, exp_wr);
    cmp_val("nv addr", wr_addr, exp_addr);
    cmp_val("nv data", wr_data, exp_data);
  endtask : check_all

  // Reference behaviour is updated first, then the frame is sent and all results compared
  task automatic cmd(input logic [3:0] a, input logic [1:0] op, input int v, input logic hv);
    int n;
    n = a[0];
    m11 = 1'($urandom % 2);
    if (a < 2 && !lk[n]) begin
      if (op == 0) w[n] = v;
      if (op == 1 && w[n] < fs) w[n]++;
      if (op == 2 && w[n] > 0 && w[n] <= fs) w[n]--;
    end
    if ((a == 2 || a == 3) && hv && op != 0) begin
      lk[n] = op == 2;
      exp_wr++;
      exp_addr = 5;
      exp_data = lk[1] * 2 + lk[0];
    end else if ((a == 2 || a == 3) && op == 0 && !lk[n]) begin
      nv[n] = v;
      exp_wr++;
      exp_addr = a;
      exp_data = v;
    end
    if (a == 4 && op == 0)
      for (int k = 0; k < 2; k++) if (!lk[k]) tc = (tc & ~(15 << 4*k)) | (v & (15 << 4*k));
    host.frame(m11, hv, op == 2'b00, {a, op, v[9:0]});
    repeat (4) @(posedge clk_sys);
    check_all();
  endtask : cmd

  task automatic do_reset();
    resetn <= 1'b0;
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    w[0] = nv[0];
    w[1] = nv[1];
    tc = 8'hFF;
    m11 = 1'b0;
    repeat (4) @(posedge clk_sys);
    check_all();
  endtask : do_reset

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict

  // Watchdog sized well above the roughly six thousand cycles the tests need
  initial begin
    repeat (60000) @(posedge clk_sys);
    errors++;
    print_verdict();
  end

  initial begin
    int vals[7];
    m11 = $urandom(59254);
    vals = '{0, 1, 'h80, 'hFF, 'h100, 'h101, 'h3FF};
    nv[0] = $urandom % 1024;
    nv[1] = 'h3FF;
    nv_wiper0 = 10'(nv[0]);
    lk = '{0, 0};
    fs = 256;
    do_reset();
    $display("test reset done");
    foreach (vals[i]) cmd(4'h0, 2'b00, vals[i], 1'b0);
    cmd(4'h1, 2'b00, $urandom % 257, 1'b0);
    $display("test decode done");
    cmd(4'h0, 2'b00, 'hFF, 1'b0);
    repeat (2) cmd(4'h0, 2'b01, 0, 1'b0);
    cmd(4'h0, 2'b00, 0, 1'b0);
    cmd(4'h0, 2'b10, 0, 1'b0);
    cmd(4'h0, 2'b00, 'h101, 1'b0);
    repeat (2) cmd(4'h0, 2'b10, 0, 1'b0);
    cmd(4'h0, 2'b00, 'h100, 1'b0);
    cmd(4'h0, 2'b10, 0, 1'b0);
    r8 <= 1'b0;
    fs = 128;
    cmd(4'h1, 2'b00, 'h7F, 1'b0);
    repeat (2) cmd(4'h1, 2'b01, 0, 1'b0);
    cmd(4'h1, 2'b00, 'h81, 1'b0);
    cmd(4'h1, 2'b10, 0, 1'b0);
    r8 <= 1'b1;
    fs = 256;
    $display("test step limits done");
    foreach (vals[i]) cmd(4'h4, 2'b00, $urandom % 256, 1'b0);
    cmd(4'h4, 2'b00, 'h77, 1'b0);
    cmd(4'h4, 2'b00, 'hFE, 1'b0);
    $display("test terminal control done");
    // Clock enable low must hold the terminals while the pin drops
    ce <= 1'b0;
    pd_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    cmp_val("frozen conn", {7'h00, cn0}, tc[3] ? tc & 7 : 3);
    ce <= 1'b1;
    repeat (6) @(posedge clk_sys);
    check_all();
    cmd(4'h0, 2'b00, 'h42, 1'b0);
    cmd(4'h4, 2'b00, 'hDA, 1'b0);
    pd_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    check_all();
    $display("test power down done");
    cmd(4'h2, 2'b10, 0, 1'b1);
    cmd(4'h2, 2'b01, 0, 1'b0);
    cmd(4'h0, 2'b00, 'h11, 1'b0);
    cmd(4'h0, 2'b01, 0, 1'b0);
    cmd(4'h2, 2'b00, 'h22, 1'b0);
    cmd(4'h4, 2'b00, 'h07, 1'b0);
    cmd(4'h1, 2'b00, 'h33, 1'b0);
    cmd(4'h3, 2'b00, 'h44, 1'b0);
    do_reset();
    cmd(4'h2, 2'b01, 0, 1'b1);
    cmd(4'h0, 2'b00, 'h12, 1'b0);
    cmd(4'h2, 2'b00, 'h2A, 1'b0);
    do_reset();
    $display("test lock done");
    print_verdict();
  end
endmodule : wiper_terminal_control_tb
